/* File: acmp_pkg.sv */
/*
 * acmp_pkg: register map, field positions, reset values and counts for the
 * two-instance comparator control block.
 * assumes: Avalon-MM slave with 32-bit data, one register per aligned word.
 */
// Notes on behaviour
// - raw result high when plus input exceeds minus input, low otherwise.
// - disabled comparator disconnects its input selections and forces zero.
// - invert_output set reports complement of raw comparison, else unchanged.
// - result readable in control register and in mirrored_result register.
// - internal result registered each instruction cycle; pin output unregistered; here the raw input first passes the acmp_sync3 flops on sys_clk.
// - timer_aligned_output captures result on falling edge of timer clock.
// - with timer prescaler, capture uses the prescaled timer clock.
// - sync only aligned to odd timers sharing first timer clock source.
// - rising or falling edges set cmp_irq_flag per their enables.
// - flag cleared only by software; coincident edge keeps it set.
// - invert or enable toggles can raise edge interrupts while disabled.
// - pos_input_select routes pin, DAC output or fixed reference.
// - two independent comparator instances with own registers and flags.
// - hysteresis_on adds hysteresis to that comparator's inputs.
// - sync cleared: timer and pin result passes through asynchronously; here only after the acmp_sync3 flops on sys_clk.
// - 3-bit neg_input_select routes pin, fixed reference or ground.
package acmp_pkg;
    localparam int unsigned ACMP_NUM   = 2;
    localparam int unsigned ACMP_AW    = 4;
    localparam int unsigned ACMP_SELW  = 3;
    localparam int unsigned ACMP_INSTR_DIV = 4;

    // word offsets
    localparam logic [3:0] ACMP_OFS_MIRROR = 4'h0;
    localparam logic [3:0] ACMP_OFS_CTLA1  = 4'h1;
    localparam logic [3:0] ACMP_OFS_CTLB1  = 4'h2;
    localparam logic [3:0] ACMP_OFS_NEG1   = 4'h3;
    localparam logic [3:0] ACMP_OFS_POS1   = 4'h4;
    localparam logic [3:0] ACMP_OFS_CTLA2  = 4'h5;
    localparam logic [3:0] ACMP_OFS_CTLB2  = 4'h6;
    localparam logic [3:0] ACMP_OFS_NEG2   = 4'h7;
    localparam logic [3:0] ACMP_OFS_POS2   = 4'h8;
    localparam logic [3:0] ACMP_OFS_FLAGS  = 4'h9;
    localparam logic [3:0] ACMP_INST_STRIDE = 4'h4;

    // cmp_control_a bits
    localparam int unsigned ACMP_A_ON   = 7;
    localparam int unsigned ACMP_A_OUT  = 6;
    localparam int unsigned ACMP_A_INV  = 4;
    localparam int unsigned ACMP_A_HYS  = 1;
    localparam int unsigned ACMP_A_SYNC = 0;
    // cmp_control_b bits
    localparam int unsigned ACMP_B_RISE = 1;
    localparam int unsigned ACMP_B_FALL = 0;

    localparam logic [7:0] ACMP_RST_CTL = 8'h00;
    localparam logic [2:0] ACMP_RST_SEL = 3'h0;
    localparam logic [2:0] ACMP_SEL_OFF = 3'h7;

    typedef enum logic [1:0] {
        ACMP_BUS_IDLE = 2'b00,
        ACMP_BUS_ACK  = 2'b01
    } acmp_bus_e;
endpackage

/* File: acmp_sync3.sv */
/*
 * acmp_sync3: three-flop synchroniser for an outside level.
 * assumes: output changes only once stages two and three agree.
 */
`timescale 1ns/10ps
module acmp_sync3 (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule

/* File: acmp_lane.sv */
/*
 * acmp_lane: one comparator's digital path: enable gate, polarity,
 * timer-aligned capture, per-instruction-cycle latch and edge pulses.
 * assumes: raw_cmp from the analog front end; tmr_clk is the prescaled
 * timer clock used as a genuine clock for the aligned capture.
 */
`timescale 1ns/10ps
module acmp_lane (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic tmr_clk,
    input  wire logic raw_cmp,
    input  wire logic cmp_on,
    input  wire logic invert_output,
    input  wire logic timer_aligned_output,
    input  wire logic instr_tick,
    output logic      result_q,
    output logic      ext_result,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    logic reported;
    logic tmr_cap_q;
    logic prev_q;

    // forced low while off, then polarity; off+invert reports one
    assign reported = (raw_cmp & cmp_on) ^ invert_output;

    // falling edge so the rising-edge timer never counts on it
    always_ff @(negedge tmr_clk or negedge reset_n) begin
        if (!reset_n) begin
            tmr_cap_q <= 1'b0;
        end else begin
            tmr_cap_q <= reported;
        end
    end

    // pin/timer path: async unless aligned
    assign ext_result = timer_aligned_output ? tmr_cap_q : reported;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= 1'b0;
            prev_q   <= 1'b0;
        end else if (instr_tick) begin
            result_q <= reported;
            prev_q   <= result_q;
        end
    end

    // one pulse per change, seen once per instruction cycle
    assign rise_pulse = instr_tick & result_q & ~prev_q;
    assign fall_pulse = instr_tick & ~result_q & prev_q;
endmodule

/* File: acmp_top.sv */
/*
 * acmp_top: control and output path of two comparators with an Avalon-MM
 * register slave, analog mux selects, hysteresis and edge flags.
 * assumes: raw comparator outputs arrive asynchronously from the analog
 * macro; timer clock comes from the first timer's prescaler.
 */
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
module acmp_top
    import acmp_pkg::*;
#(
    parameter int unsigned NUM = acmp_pkg::ACMP_NUM
) (
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    input  wire logic [acmp_pkg::ACMP_AW-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    output logic [1:0]                      avs_response,
    input  wire logic                       tmr_clk,
    input  wire logic [NUM-1:0]             raw_cmp,
    output logic [NUM-1:0]                  ext_result,
    output logic [NUM-1:0]                  cmp_irq_flag,
    output logic [NUM-1:0]                  hysteresis_on,
    output logic [NUM*3-1:0]                pos_input_select,
    output logic [NUM*3-1:0]                neg_input_select
);
    import acmp_pkg::*;

    // ------------------------------------------------------------
    // instruction-cycle tick
    // ------------------------------------------------------------
    logic [1:0] div_q;
    logic       instr_tick;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign instr_tick = (div_q == 2'(ACMP_INSTR_DIV - 1));

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctla_q [NUM];
    logic [1:0] ctlb_q [NUM];
    logic [2:0] neg_q  [NUM];
    logic [2:0] pos_q  [NUM];
    logic [NUM-1:0] flag_q;
    logic [NUM-1:0] result_q;
    logic [NUM-1:0] rise_p;
    logic [NUM-1:0] fall_p;
    logic [NUM-1:0] raw_s;

    acmp_bus_e  bus_q;
    logic       req;
    logic       wr_go;
    logic [3:0] addr;
    logic [7:0] wb;

    assign req   = avs_read | avs_write;
    assign addr  = avs_address;
    assign wb    = avs_writedata[7:0];
    // one wait state, accepted on the ack cycle
    assign avs_waitrequest = req & (bus_q == ACMP_BUS_IDLE);
    assign wr_go = avs_write & (bus_q == ACMP_BUS_ACK) & avs_byteenable[0];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_q <= ACMP_BUS_IDLE;
        end else begin
            unique case (bus_q)
                ACMP_BUS_IDLE: begin
                    if (req) begin
                        bus_q <= ACMP_BUS_ACK;
                    end
                end
                ACMP_BUS_ACK: begin
                    bus_q <= ACMP_BUS_IDLE;
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : gen_cmp
            localparam logic [3:0] BASE = 4'(g) * ACMP_INST_STRIDE;

            acmp_sync3 u_sync (
                .sys_clk (sys_clk),
                .reset_n (reset_n),
                .din     (raw_cmp[g]),
                .dout    (raw_s[g])
            );

            // each instance owns its own control set
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    ctla_q[g] <= ACMP_RST_CTL;
                    ctlb_q[g] <= 2'h0;
                    neg_q[g]  <= ACMP_RST_SEL;
                    pos_q[g]  <= ACMP_RST_SEL;
                end else if (wr_go) begin
                    if (addr == ACMP_OFS_CTLA1 + BASE) begin
                        ctla_q[g] <= wb & 8'h93;
                    end
                    if (addr == ACMP_OFS_CTLB1 + BASE) begin
                        ctlb_q[g] <= wb[1:0];
                    end
                    if (addr == ACMP_OFS_NEG1 + BASE) begin
                        neg_q[g] <= wb[2:0];
                    end
                    if (addr == ACMP_OFS_POS1 + BASE) begin
                        pos_q[g] <= wb[2:0];
                    end
                end
            end

            acmp_lane u_lane (
                .sys_clk              (sys_clk),
                .reset_n              (reset_n),
                .tmr_clk              (tmr_clk),
                .raw_cmp              (raw_s[g]),
                .cmp_on               (ctla_q[g][ACMP_A_ON]),
                .invert_output        (ctla_q[g][ACMP_A_INV]),
                .timer_aligned_output (ctla_q[g][ACMP_A_SYNC]),
                .instr_tick           (instr_tick),
                .result_q             (result_q[g]),
                .ext_result           (ext_result[g]),
                .rise_pulse           (rise_p[g]),
                .fall_pulse           (fall_p[g])
            );

            // disabled comparator parks both muxes on the off code
            assign pos_input_select[g*3 +: 3] =
                ctla_q[g][ACMP_A_ON] ? pos_q[g] : ACMP_SEL_OFF;
            assign neg_input_select[g*3 +: 3] =
                ctla_q[g][ACMP_A_ON] ? neg_q[g] : ACMP_SEL_OFF;
            assign hysteresis_on[g] =
                ctla_q[g][ACMP_A_ON] & ctla_q[g][ACMP_A_HYS];

            // set beats a coincident clear
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    flag_q[g] <= 1'b0;
                end else if ((rise_p[g] & ctlb_q[g][ACMP_B_RISE]) |
                             (fall_p[g] & ctlb_q[g][ACMP_B_FALL])) begin
                    flag_q[g] <= 1'b1;
                end else if (wr_go && addr == ACMP_OFS_FLAGS &&
                             !wb[g]) begin
                    flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign cmp_irq_flag = flag_q;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [31:0] rd_d;
    logic        hit;

    always_comb begin
        rd_d = 32'h0000_0000;
        hit  = 1'b1;
        if (addr == ACMP_OFS_MIRROR) begin
            rd_d[NUM-1:0] = result_q;
        end else if (addr == ACMP_OFS_FLAGS) begin
            rd_d[NUM-1:0] = flag_q;
        end else if (addr == ACMP_OFS_CTLA1) begin
            rd_d[7:0] = ctla_q[0];
            rd_d[ACMP_A_OUT] = result_q[0];
        end else if (addr == ACMP_OFS_CTLB1) begin
            rd_d[1:0] = ctlb_q[0];
        end else if (addr == ACMP_OFS_NEG1) begin
            rd_d[2:0] = neg_q[0];
        end else if (addr == ACMP_OFS_POS1) begin
            rd_d[2:0] = pos_q[0];
        end else if (addr == ACMP_OFS_CTLA2) begin
            rd_d[7:0] = ctla_q[1];
            rd_d[ACMP_A_OUT] = result_q[1];
        end else if (addr == ACMP_OFS_CTLB2) begin
            rd_d[1:0] = ctlb_q[1];
        end else if (addr == ACMP_OFS_NEG2) begin
            rd_d[2:0] = neg_q[1];
        end else if (addr == ACMP_OFS_POS2) begin
            rd_d[2:0] = pos_q[1];
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (req && bus_q == ACMP_BUS_IDLE) begin
            avs_readdata <= avs_read ? rd_d : 32'h0000_0000;
            // unmapped address answers slave error
            avs_response <= hit ? 2'b00 : 2'b10;
        end
    end
endmodule

/* File: acmp_top_monitor.sv */
/*
 * acmp_top_monitor: port-level assertions on the comparator control block.
 * assumes: bound to acmp_top; one clock, async active-low reset.
 */
`timescale 1ns/10ps
module acmp_top_monitor
    import acmp_pkg::*;
#(
    parameter int unsigned NUM = acmp_pkg::ACMP_NUM
) (
    input wire logic                         sys_clk,
    input wire logic                         reset_n,
    input wire logic [acmp_pkg::ACMP_AW-1:0] avs_address,
    input wire logic                         avs_read,
    input wire logic                         avs_write,
    input wire logic [31:0]                  avs_writedata,
    input wire logic [3:0]                   avs_byteenable,
    input wire logic                         avs_waitrequest,
    input wire logic [1:0]                   avs_response,
    input wire logic [NUM-1:0]               cmp_irq_flag,
    input wire logic [NUM-1:0]               hysteresis_on,
    input wire logic [NUM*3-1:0]             pos_input_select,
    input wire logic [NUM*3-1:0]             neg_input_select
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // write accepted on lane 0 at the given word
    sequence s_wr_ack(logic [3:0] a);
        avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == a;
    endsequence
    sequence s_clr(int g);
        s_wr_ack(ACMP_OFS_FLAGS) ##0 !avs_writedata[g];
    endsequence
    a_wait_first: assert property ((avs_read || avs_write) &&
        !$past(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request not held off in its first cycle");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("more than one wait state");
    a_flag_clr0: assert property ($fell(cmp_irq_flag[0]) |->
        $past(avs_write && !avs_waitrequest && avs_address == ACMP_OFS_FLAGS
        && avs_byteenable[0] && !avs_writedata[0]))
        else $error("flag 0 fell without a clearing write");
    a_flag_clr1: assert property ($fell(cmp_irq_flag[1]) |->
        $past(avs_write && !avs_waitrequest && avs_address == ACMP_OFS_FLAGS
        && avs_byteenable[0] && !avs_writedata[1]))
        else $error("flag 1 fell without a clearing write");
    a_off_sel: assert property (s_wr_ack(ACMP_OFS_CTLA1) ##0
        !avs_writedata[ACMP_A_ON] |=> neg_input_select[2:0] == ACMP_SEL_OFF
        && pos_input_select[2:0] == ACMP_SEL_OFF && !hysteresis_on[0])
        else $error("disabled lane 0 still connected");
    a_off_two: assert property (s_wr_ack(ACMP_OFS_CTLA2) ##0
        !avs_writedata[ACMP_A_ON] |=> neg_input_select[5:3] == ACMP_SEL_OFF)
        else $error("disabled lane 1 still connected");
    a_hys_on: assert property (s_wr_ack(ACMP_OFS_CTLA1) ##0
        avs_writedata[ACMP_A_ON] && avs_writedata[ACMP_A_HYS]
        |=> hysteresis_on[0]) else $error("hysteresis not applied");
    a_neg_sel: assert property (s_wr_ack(ACMP_OFS_NEG1) ##0 hysteresis_on[0]
        |=> neg_input_select[2:0] == $past(avs_writedata[2:0]))
        else $error("minus select not routed");
    a_pos_sel: assert property (s_wr_ack(ACMP_OFS_POS1) ##0 hysteresis_on[0]
        |=> pos_input_select[2:0] == $past(avs_writedata[2:0]))
        else $error("plus select not routed");
    a_bad_addr: assert property (avs_read && !avs_waitrequest &&
        avs_address > ACMP_OFS_FLAGS |-> avs_response == 2'b10)
        else $error("unmapped read not refused");
endmodule
bind acmp_top acmp_top_monitor #(.NUM(NUM)) acmp_top_monitor_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .cmp_irq_flag(cmp_irq_flag), .hysteresis_on(hysteresis_on),
    .pos_input_select(pos_input_select), .neg_input_select(neg_input_select));

/* File: acmp_tmr_model.sv */
/*
 * acmp_tmr_model: gated timer and interrupt combiner beside the block.
 * assumes: prescaled timer clock made here from sys_clk, divide by four.
 */
`timescale 1ns/10ps
module acmp_tmr_model (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       gate_in,
    input  wire logic [1:0] irq_flags,
    output logic            tmr_clk,
    output logic [15:0]     tmr_count,
    output logic            irq_req
);
    // ------------------------------------------------------------
    // timer
    // ------------------------------------------------------------
    logic [1:0] div_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) div_q <= 2'h0;
        else div_q <= div_q + 2'h1;
    end
    assign tmr_clk = div_q[1];
    // counting on the rising edge keeps clear of the falling capture
    always_ff @(posedge tmr_clk or negedge reset_n) begin
        if (!reset_n) tmr_count <= 16'h0000;
        else if (gate_in) tmr_count <= tmr_count + 16'h0001;
    end
    // mask and both gates held set here
    assign irq_req = |(irq_flags & 2'b11) & 1'b1 & 1'b1;
endmodule

/* File: acmp_top_tb_top.sv */
/*
 * acmp_top_tb_top: self-checking bench for the comparator control block.
 * assumes: the timer model supplies tmr_clk; raw inputs driven here.
 */
`timescale 1ns/10ps
module acmp_top_tb_top;
    import acmp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                sys_clk, reset_n, avs_read, avs_write;
    logic [ACMP_AW-1:0]  avs_address;
    logic [31:0]         avs_writedata, avs_readdata;
    logic [3:0]          avs_byteenable;
    logic                avs_waitrequest, tmr_clk, irq_req;
    logic [1:0]          avs_response, raw_cmp, ext_result;
    logic [1:0]          cmp_irq_flag, hysteresis_on;
    logic [5:0]          pos_input_select, neg_input_select;
    logic [15:0]         tmr_count, c0;
    logic [9:0]          exp_q[$];
    logic [2:0]          ns, ps;
    logic                b;
    int                  errors, tests_run;
    realtime             t_neg;

    acmp_top acmp_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .tmr_clk(tmr_clk), .raw_cmp(raw_cmp), .ext_result(ext_result),
        .cmp_irq_flag(cmp_irq_flag), .hysteresis_on(hysteresis_on),
        .pos_input_select(pos_input_select),
        .neg_input_select(neg_input_select));
    acmp_tmr_model acmp_tmr_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .gate_in(ext_result[0]), .irq_flags(cmp_irq_flag),
        .tmr_clk(tmr_clk), .tmr_count(tmr_count), .irq_req(irq_req));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // time of the last capture edge, for the aligned-output check
    always @(negedge tmr_clk) t_neg = $realtime;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // e holds the expected response above the expected low byte
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [7:0] d, input logic [9:0] e);
        if (!w) exp_q.push_back(e);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    // read data taken at the edge where waitrequest is low
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check("readback", {avs_response, avs_readdata[7:0]},
                  exp_q.pop_front());
    end
    initial begin
        #100us;
        errors++;
        stop_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 4'h0; avs_writedata = 32'h0; avs_byteenable = 4'hF;
        raw_cmp = 2'b00; errors = 0; tests_run = 0;
        void'($urandom(32'hB3EA));
        idle(12);
        reset_n <= 1'b1;
        idle(1);
        check("sel_rst", neg_input_select, 16'h003F);
        check("sel_rst_p", pos_input_select, 16'h003F);
        xfer(1'b0, ACMP_OFS_CTLA1, 8'h00, 10'h000);
        $display("test reset done");
        raw_cmp <= 2'b01;
        xfer(1'b1, ACMP_OFS_CTLB1, 8'h03, 10'h000);
        xfer(1'b1, ACMP_OFS_CTLA1, 8'h82, 10'h000);
        idle(20);
        xfer(1'b0, ACMP_OFS_CTLA1, 8'h00, 10'h0C2);
        xfer(1'b0, ACMP_OFS_MIRROR, 8'h00, 10'h001);
        check("ext", ext_result, 16'h0001);
        check("hys", hysteresis_on, 16'h0001);
        check("rise", cmp_irq_flag, 16'h0001);
        check("irq", 16'(irq_req), 16'h0001);
        xfer(1'b1, ACMP_OFS_FLAGS, 8'h00, 10'h000);
        check("clr", cmp_irq_flag, 16'h0000);
        check("irq_clr", 16'(irq_req), 16'h0000);
        raw_cmp <= 2'b00;
        idle(20);
        check("fall", cmp_irq_flag, 16'h0001);
        xfer(1'b1, ACMP_OFS_CTLA1, 8'h92, 10'h000);
        idle(20);
        xfer(1'b0, ACMP_OFS_CTLA1, 8'h00, 10'h0D2);
        $display("test result done");
        xfer(1'b1, ACMP_OFS_FLAGS, 8'h00, 10'h000);
        xfer(1'b1, ACMP_OFS_CTLA1, 8'h00, 10'h000);
        idle(20);
        check("off_edge", cmp_irq_flag, 16'h0001);
        check("off_sel", pos_input_select[2:0], 16'h0007);
        $display("test disable done");
        ns = 3'($urandom % 7);
        ps = 3'($urandom % 7);
        xfer(1'b1, ACMP_OFS_CTLA1, 8'h82, 10'h000);
        xfer(1'b1, ACMP_OFS_NEG1, {5'h00, ns}, 10'h000);
        xfer(1'b1, ACMP_OFS_POS1, {5'h00, ps}, 10'h000);
        check("neg", neg_input_select[2:0], 16'(ns));
        check("pos", pos_input_select[2:0], 16'(ps));
        b = 1'($urandom % 2);
        raw_cmp <= {b, 1'b0};
        xfer(1'b1, ACMP_OFS_CTLA2, 8'h80, 10'h000);
        idle(20);
        xfer(1'b0, ACMP_OFS_CTLA2, 8'h00, {3'h0, b, 6'h00} | 10'h080);
        xfer(1'b0, ACMP_OFS_MIRROR, 8'h00, {8'h00, b, 1'b0});
        xfer(1'b1, ACMP_OFS_CTLA2, 8'h00, 10'h000);
        $display("test second lane done");
        raw_cmp <= 2'b01;
        xfer(1'b1, ACMP_OFS_CTLA1, 8'h83, 10'h000);
        idle(30);
        check("sync", ext_result[0], 16'h0001);
        c0 = tmr_count;
        idle(20);
        check("count", 16'(tmr_count > c0), 16'h0001);
        // drop the input on a rising timer edge: only the falling capture
        // edge may pass it on to the aligned output
        @(posedge tmr_clk);
        raw_cmp <= 2'b00;
        @(negedge ext_result[0]);
        check("sync_edge", 16'($realtime == t_neg), 16'h0001);
        @(posedge sys_clk);
        avs_byteenable <= 4'hE;
        xfer(1'b1, ACMP_OFS_CTLB1, 8'h00, 10'h000);
        avs_byteenable <= 4'hF;
        xfer(1'b0, ACMP_OFS_CTLB1, 8'h00, 10'h003);
        xfer(1'b0, 4'hF, 8'h00, 10'h200);
        $display("test sync done");
        idle(2);
        stop_test();
    end
endmodule
